// ===== dfl_decode.sv
// Decoder and executor for double, shift-immediate and long-immediate instructions
`timescale 1ns/10ps
// Notes on behaviour
// RL1 - Double function 10000000000 writes src_b plus src_a, double precision.
// RL2 - Double function 10010000000 writes src_b minus src_a.
// RL3 - Double function 10100000000 writes src_b times src_a.
// RL4 - Double function 10110000000 writes src_b divided by src_a.
// RL5 - Unordered compare writes 1 when either operand is NaN, else 0.
// RL6 - Less, equal, less-or-equal compares write 1 when src_b relation src_a holds.
// RL7 - Greater, not-equal, greater-or-equal compares write 1 when the relation holds.
// RL8 - Function 11010000000 converts integer src_a to double.
// RL9 - Function 11100000000 converts double src_a to a long integer.
// RL10 - Function 11110000000 writes the double square root of src_a.
// RL11 - Opcode 011001 shifts right by shift_amount, logical or sign-filling by prefix.
// RL12 - Prefix 00100000 shifts src_a left by shift_amount, zero filled.
// RL13 - Field extract places src_a shifted right into low field bits, upper cleared.
// RL14 - Opcode 011010 is the long-immediate group; sub-op 00000 adds immediate.
// RL15 - Reverse-subtract and keep-carry add variants operate without the carry flag.
// RL16 - Carry-using long-immediate sub-operations add the carry flag into the result.
// RL17 - Sub-op 10000 ORs the sign-extended immediate into the 64-bit dest.
// RL18 - Sub-op 10001 ANDs the sign-extended immediate into the 64-bit dest.
// RL19 - Reverse-subtract adds immediate to inverted dest plus one or plus carry.
// RL20 - Bit 0 is the instruction MSB; opcode leads, register fields five bits.
// RL21 - Double and long-immediate groups are illegal unless 64-bit mode is on.
module dfl_decode
  import dfl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cfg_long_mode,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] src_a_val,
  input  wire logic [63:0] src_b_val,
  input  wire logic [63:0] dest_val,
  input  wire logic        carry_flag,
  input  wire logic        fpu_done,
  input  wire logic [63:0] fpu_result,
  output logic             busy,
  output logic             wb_valid,
  output logic [4:0]       wb_reg,
  output logic [63:0]      wb_data,
  output logic             carry_wr,
  output logic             carry_val,
  output logic             illegal_instr,
  output logic             fpu_start,
  output dfl_fp_op_e       fpu_op,
  output logic [63:0]      fpu_lhs,
  output logic [63:0]      fpu_rhs
);

  // ---------------------------------------------------------------
  // Conversion helpers
  // ---------------------------------------------------------------
  // Signed 64-bit integer to double, round to nearest even
  function automatic logic [63:0] long_to_dbl(input logic [63:0] v);
    logic        sgn;
    logic [63:0] mag;
    logic [63:0] norm;
    logic [52:0] man;
    logic [10:0] ex;
    int          msb;
    sgn = v[63];
    mag = sgn ? (~v + 64'h1) : v;
    msb = 0;
    for (int i = 0; i < 64; i++)
      if (mag[i])
        msb = i;
    norm = mag << (63 - msb);
    man  = {1'b0, norm[62:11]};
    if (norm[10] && ((|norm[9:0]) || man[0]))
      man = man + 53'h1;
    ex = EXP_BIAS + 11'(msb);
    if (man[52])
      ex = ex + 11'h1;
    long_to_dbl = (mag == 64'h0) ? 64'h0 : {sgn, ex, man[51:0]};
  endfunction

  // Double to signed 64-bit integer, truncated toward zero, saturating
  function automatic logic [63:0] dbl_to_long(input logic [63:0] d);
    logic [10:0]  ex;
    logic [10:0]  sh;
    logic [116:0] mag;
    logic [63:0]  res;
    ex  = d[62:52];
    sh  = ex - EXP_BIAS;
    mag = {64'h0, 1'b1, d[51:0]};
    if (ex == EXP_MAX && d[51:0] != 52'h0)
      res = LONG_MAX;
    else if (ex < EXP_BIAS)
      res = 64'h0;
    else if (sh >= 11'd63)
      res = d[63] ? LONG_MIN : LONG_MAX;
    else
    begin
      mag = mag << sh;
      res = 64'(mag[116:52]);
      res = d[63] ? (~res + 64'h1) : res;
    end
    dbl_to_long = res;
  endfunction

  // ---------------------------------------------------------------
  // Field split, bit 0 taken as the MSB
  // ---------------------------------------------------------------
  logic [5:0]  f_opc;
  logic [4:0]  f_rd;
  logic [4:0]  f_sub;
  logic [10:0] f_func;
  logic [7:0]  f_spfx;
  logic [4:0]  f_ext;
  logic [4:0]  f_width;
  logic [4:0]  f_shamt;
  logic [63:0] imm_sx;

  assign f_opc   = instr[OPC_LSB +: 6];  // RL20
  assign f_rd    = instr[RD_LSB +: 5];
  assign f_sub   = instr[SUBOP_LSB +: 5];
  assign f_func  = instr[FUNC_LSB +: 11];
  assign f_spfx  = instr[SPFX_LSB +: 8];
  assign f_ext   = instr[EXT_LSB +: 5];
  assign f_width = instr[FW_LSB +: 5];
  assign f_shamt = instr[FS_LSB +: 5];
  assign imm_sx  = {{48{instr[15]}}, instr[15:0]};

  // ---------------------------------------------------------------
  // Double comparator
  // ---------------------------------------------------------------
  dfl_cmp_if cmp_bus ();

  assign cmp_bus.lhs = src_b_val;
  assign cmp_bus.rhs = src_a_val;

  dfl_dcmp u_dcmp
  (
    .c (cmp_bus.cmp)
  );

  // ---------------------------------------------------------------
  // Long-immediate adder
  // ---------------------------------------------------------------
  logic [63:0] li_opnd;
  logic        li_cin;
  logic [64:0] li_sum;
  logic        li_rev;
  logic        li_usec;

  // Sub-op bit 0 picks reverse, bit 1 picks carry-in
  assign li_rev  = f_sub[0];
  assign li_usec = f_sub[1];
  assign li_opnd = li_rev ? ~dest_val : dest_val;  // RL19
  assign li_cin  = li_usec ? carry_flag : li_rev;  // RL15 RL16 RL19
  assign li_sum  = {1'b0, imm_sx} + {1'b0, li_opnd} + {64'h0, li_cin};

  // ---------------------------------------------------------------
  // Decode and single-cycle results
  // ---------------------------------------------------------------
  logic        next_wr;
  logic [63:0] next_data;
  logic        next_cwr;
  logic        next_illegal;
  logic        next_fp;
  dfl_fp_op_e  next_fp_op;
  logic [31:0] shift_res;
  logic [31:0] field_mask;

  assign field_mask = ~(32'hffffffff << f_width);

  // Function bits 9 to 7 name the operation; of the unit operations only square root sets bit 9
  assign next_fp_op = dfl_fp_op_e'(f_func[9] ? 3'h4 : {1'b0, f_func[8:7]});

  always_comb
  begin
    next_wr      = 1'b0;
    next_data    = DATA_RST;
    next_cwr     = 1'b0;
    next_illegal = 1'b0;
    next_fp      = 1'b0;
    shift_res    = 32'h0;
    unique case (f_opc)
      OPC_FLOAT:
      begin
        next_wr = cfg_long_mode;
        unique case (f_func)
          FN_DOUBLE_ADD, FN_DOUBLE_REVERSE_SUBTRACT, FN_DOUBLE_MULTIPLY, FN_DOUBLE_DIVIDE, FN_DSQRT:
            next_fp = 1'b1;  // RL1 RL2 RL3 RL4 RL10
          FN_DUN:
            next_data = {63'h0, cmp_bus.unordered};  // RL5
          FN_DLT:
            next_data = {63'h0, cmp_bus.less};  // RL6
          FN_DEQ:
            next_data = {63'h0, cmp_bus.equal};  // RL6
          FN_DLE:
            next_data = {63'h0, cmp_bus.less | cmp_bus.equal};  // RL6
          FN_DGT:
            next_data = {63'h0, ~cmp_bus.unordered & ~cmp_bus.less & ~cmp_bus.equal};  // RL7
          FN_DNE:
            next_data = {63'h0, ~cmp_bus.equal};  // RL7
          FN_DGE:
            next_data = {63'h0, ~cmp_bus.unordered & ~cmp_bus.less};  // RL7
          FN_DFLT:
            next_data = long_to_dbl(src_a_val);  // RL8
          FN_DOUBLE_TO_LONG:
            next_data = dbl_to_long(src_a_val);  // RL9
          default:
            next_wr = 1'b0;
        endcase
        next_illegal = !(next_wr || (next_fp && cfg_long_mode));  // RL21
        next_fp      = next_fp && cfg_long_mode;
        next_wr      = next_wr && !next_fp;
      end
      OPC_SHIFTI:
      begin
        next_wr = 1'b1;
        if ((f_ext & EXT_MASK) == PFX_EXT)
          shift_res = (src_a_val[31:0] >> f_shamt) & field_mask;  // RL13
        else if (f_spfx == PFX_SRL)
          shift_res = src_a_val[31:0] >> f_shamt;  // RL11
        else if (f_spfx == PFX_SRA)
          shift_res = 32'($signed(src_a_val[31:0]) >>> f_shamt);  // RL11
        else if (f_spfx == PFX_SLL)
          shift_res = src_a_val[31:0] << f_shamt;  // RL12
        else
          next_wr = 1'b0;
        next_data    = {32'h0, shift_res};
        next_illegal = !next_wr;
      end
      OPC_LONGIMM:
      begin
        next_wr = cfg_long_mode;  // RL21
        unique case (f_sub)
          SUB_ADD, SUB_RSUB, SUB_ADDC, SUB_RSUBC:
          begin
            next_data = li_sum[63:0];  // RL14 RL15 RL16
            next_cwr  = cfg_long_mode;
          end
          SUB_ADDK, SUB_RSUBK, SUB_ADDKC, SUB_RSBKC:
            next_data = li_sum[63:0];  // RL15 RL16
          SUB_OR:
            next_data = dest_val | imm_sx;  // RL17
          SUB_AND:
            next_data = dest_val & imm_sx;  // RL18
          default:
            next_wr = 1'b0;
        endcase
        next_illegal = !next_wr;
      end
      default:
        next_wr = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencing: single-cycle ops write next edge, arithmetic waits
  // ---------------------------------------------------------------
  dfl_state_e state;
  logic       take;

  // New instructions are ignored while an arithmetic op is outstanding
  assign take = instr_valid && (state == DFL_IDLE);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= DFL_IDLE;
    else
    begin
      unique case (state)
        DFL_IDLE:
          if (take && next_fp)
            state <= DFL_WAIT;
        DFL_WAIT:
          if (fpu_done)
            state <= DFL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy <= 1'b0;
    else if (take && next_fp)
      busy <= 1'b1;
    else if (state == DFL_WAIT && fpu_done)
      busy <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fpu_start <= 1'b0;
      fpu_op    <= DFL_FP_ADD;
      fpu_lhs   <= DATA_RST;
      fpu_rhs   <= DATA_RST;
    end
    else
    begin
      fpu_start <= take && next_fp;  // RL1 RL2 RL3 RL4 RL10
      if (take && next_fp)
      begin
        fpu_op  <= next_fp_op;
        fpu_lhs <= src_b_val;
        fpu_rhs <= src_a_val;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_valid      <= 1'b0;
      wb_reg        <= 5'h0;
      wb_data       <= DATA_RST;
      carry_wr      <= 1'b0;
      carry_val     <= 1'b0;
      illegal_instr <= 1'b0;
    end
    else
    begin
      wb_valid      <= (take && next_wr) || (state == DFL_WAIT && fpu_done);
      carry_wr      <= take && next_cwr;
      illegal_instr <= take && next_illegal;
      if (take)
      begin
        wb_reg    <= f_rd;
        wb_data   <= next_data;
        carry_val <= li_sum[64];
      end
      else if (state == DFL_WAIT && fpu_done)
        wb_data <= fpu_result;
    end
  end

endmodule

// ===== dfl_pkg.sv
// Shared constants and types for the double, shift-immediate and long-immediate decoder
package dfl_pkg;

  // ---------------------------------------------------------------
  // Instruction fields (bit 0 is the MSB of the 32-bit word)
  // ---------------------------------------------------------------
  localparam int OPC_LSB    = 26;
  localparam int RD_LSB     = 21;
  localparam int RA_LSB     = 16;
  localparam int SUBOP_LSB  = 16;
  localparam int FUNC_LSB   = 0;
  localparam int SPFX_LSB   = 5;
  localparam int FW_LSB     = 5;
  localparam int FS_LSB     = 0;
  localparam int EXT_LSB    = 11;

  localparam logic [5:0] OPC_FLOAT   = 6'h16;
  localparam logic [5:0] OPC_SHIFTI  = 6'h19;
  localparam logic [5:0] OPC_LONGIMM = 6'h1a;

  // ---------------------------------------------------------------
  // Function fields of the double group
  // ---------------------------------------------------------------
  localparam logic [10:0] FN_DOUBLE_ADD  = 11'h400;
  localparam logic [10:0] FN_DOUBLE_REVERSE_SUBTRACT = 11'h480;
  localparam logic [10:0] FN_DOUBLE_MULTIPLY  = 11'h500;
  localparam logic [10:0] FN_DOUBLE_DIVIDE  = 11'h580;
  localparam logic [10:0] FN_DUN   = 11'h600;
  localparam logic [10:0] FN_DLT   = 11'h610;
  localparam logic [10:0] FN_DEQ   = 11'h620;
  localparam logic [10:0] FN_DLE   = 11'h630;
  localparam logic [10:0] FN_DGT   = 11'h640;
  localparam logic [10:0] FN_DNE   = 11'h650;
  localparam logic [10:0] FN_DGE   = 11'h660;
  localparam logic [10:0] FN_DFLT  = 11'h680;
  localparam logic [10:0] FN_DOUBLE_TO_LONG = 11'h700;
  localparam logic [10:0] FN_DSQRT = 11'h780;

  // ---------------------------------------------------------------
  // Shift-immediate prefixes and long-immediate sub-operations
  // ---------------------------------------------------------------
  localparam logic [7:0] PFX_SRL = 8'h00;
  localparam logic [7:0] PFX_SRA = 8'h10;
  localparam logic [7:0] PFX_SLL = 8'h20;
  localparam logic [4:0] PFX_EXT = 5'h08;
  localparam logic [4:0] EXT_MASK = 5'h1b;

  localparam logic [4:0] SUB_ADD   = 5'h00;
  localparam logic [4:0] SUB_RSUB  = 5'h01;
  localparam logic [4:0] SUB_ADDC  = 5'h02;
  localparam logic [4:0] SUB_RSUBC = 5'h03;
  localparam logic [4:0] SUB_ADDK  = 5'h04;
  localparam logic [4:0] SUB_RSUBK = 5'h05;
  localparam logic [4:0] SUB_ADDKC = 5'h06;
  localparam logic [4:0] SUB_RSBKC = 5'h07;
  localparam logic [4:0] SUB_OR    = 5'h10;
  localparam logic [4:0] SUB_AND   = 5'h11;

  // ---------------------------------------------------------------
  // Double-precision constants and reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] EXP_BIAS = 11'h3ff;
  localparam logic [10:0] EXP_MAX  = 11'h7ff;
  localparam logic [63:0] LONG_MAX = 64'h7fffffffffffffff;
  localparam logic [63:0] LONG_MIN = 64'h8000000000000000;
  localparam logic [63:0] DATA_RST = 64'h0;

  typedef enum logic [2:0] {
    DFL_FP_ADD  = 3'h0,
    DFL_FP_RSUB = 3'h1,
    DFL_FP_MUL  = 3'h2,
    DFL_FP_DIV  = 3'h3,
    DFL_FP_SQRT = 3'h4
  } dfl_fp_op_e;

  typedef enum logic [0:0] {
    DFL_IDLE = 1'b0,
    DFL_WAIT = 1'b1
  } dfl_state_e;

endpackage

// ===== dfl_cmp_if.sv
// Carrier between the decoder and the double comparator
`timescale 1ns/10ps
interface dfl_cmp_if;
  logic [63:0] lhs;
  logic [63:0] rhs;
  logic        unordered;
  logic        less;
  logic        equal;

  modport req
  (
    output lhs,
    output rhs,
    input  unordered,
    input  less,
    input  equal
  );

  modport cmp
  (
    input  lhs,
    input  rhs,
    output unordered,
    output less,
    output equal
  );
endinterface

// ===== dfl_dcmp.sv
// Combinational IEEE double comparator, lhs against rhs
`timescale 1ns/10ps
module dfl_dcmp
  import dfl_pkg::*;
(
  dfl_cmp_if.cmp c
);

  function automatic logic is_nan(input logic [63:0] v);
    is_nan = (v[62:52] == EXP_MAX) && (v[51:0] != 52'h0);
  endfunction

  logic both_zero;
  logic mag_lt;
  logic mag_gt;

  assign both_zero = (c.lhs[62:0] == 63'h0) && (c.rhs[62:0] == 63'h0);
  assign mag_lt    = c.lhs[62:0] < c.rhs[62:0];
  assign mag_gt    = c.lhs[62:0] > c.rhs[62:0];

  // Any NaN makes the pair unordered; every ordered relation is then false
  always_comb
  begin
    c.unordered = is_nan(c.lhs) || is_nan(c.rhs);
    c.equal     = 1'b0;
    c.less      = 1'b0;
    if (!c.unordered)
    begin
      // Plus and minus zero compare equal
      c.equal = both_zero || (c.lhs == c.rhs);
      if (!c.equal)
      begin
        if (c.lhs[63] != c.rhs[63])
          c.less = c.lhs[63];
        else if (c.lhs[63])
          c.less = mag_gt;
        else
          c.less = mag_lt;
      end
    end
  end

endmodule

// ===== dfl_decode_checker.sv
// Port-level assertion checker for the double, shift and long-immediate decoder
`timescale 1ns/10ps
module dfl_decode_checker
  import dfl_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cfg_long_mode,
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] src_a_val,
  input wire logic [63:0] src_b_val,
  input wire logic [63:0] dest_val,
  input wire logic        carry_flag,
  input wire logic        fpu_done,
  input wire logic [63:0] fpu_result,
  input wire logic        busy,
  input wire logic        wb_valid,
  input wire logic [4:0]  wb_reg,
  input wire logic [63:0] wb_data,
  input wire logic        carry_wr,
  input wire logic        carry_val,
  input wire logic        illegal_instr,
  input wire logic        fpu_start,
  input wire dfl_fp_op_e  fpu_op,
  input wire logic [63:0] fpu_lhs,
  input wire logic [63:0] fpu_rhs
);
  logic        take;
  logic        lmode;
  logic [63:0] imm_sx;
  assign take = instr_valid && !busy;
  assign lmode = take && cfg_long_mode && instr[31:26] == OPC_LONGIMM;
  assign imm_sx = {{48{instr[15]}}, instr[15:0]};

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_DOUBLE_ADD_START: assert property (
    take && cfg_long_mode && instr[31:26] == OPC_FLOAT && instr[10:0] == FN_DOUBLE_ADD
    |=> fpu_start && busy && fpu_op == DFL_FP_ADD
    && fpu_lhs == $past(src_b_val) && fpu_rhs == $past(src_a_val))
    else $error("add did not start the unit");
  AST_FPU_FINISH: assert property (busy && fpu_done
    |=> wb_valid && !busy && wb_data == $past(fpu_result))
    else $error("unit result not written");
  AST_START_ONCE: assert property (fpu_start |=> !fpu_start)
    else $error("start longer than one cycle");
  AST_LONG_OFF: assert property (
    take && !cfg_long_mode && instr[31:26] == OPC_LONGIMM
    |=> illegal_instr && !wb_valid && !carry_wr)
    else $error("long group accepted with mode off");
  AST_ILLEGAL_QUIET: assert property (illegal_instr |-> !wb_valid && !fpu_start)
    else $error("illegal instruction had an effect");
  AST_SLL: assert property (
    take && instr[31:26] == OPC_SHIFTI && instr[12:5] == PFX_SLL
    && (instr[15:11] & EXT_MASK) != PFX_EXT
    |=> wb_valid && wb_reg == $past(instr[25:21])
    && wb_data == {32'h0, $past(src_a_val[31:0]) << $past(instr[4:0])})
    else $error("left shift result wrong");
  AST_LONG_IMM_OR: assert property (lmode && instr[20:16] == SUB_OR
    |=> wb_valid && !carry_wr && wb_data == ($past(dest_val) | $past(imm_sx)))
    else $error("long or result wrong");
  AST_KEEP: assert property (lmode && instr[20:18] == 3'h1 |=> wb_valid && !carry_wr)
    else $error("keep variant wrote carry");
  AST_LONG_IMM_ADD: assert property (lmode && instr[20:16] == SUB_ADD
    |=> carry_wr && {carry_val, wb_data} == {1'b0, $past(dest_val)} + {1'b0, $past(imm_sx)})
    else $error("long add result wrong");

  cover property (fpu_start);
  cover property (busy && instr_valid);
  cover property (illegal_instr);
  cover property (carry_wr && carry_val);
endmodule

// ===== tb_dfl_decode.sv
// Self-checking testbench for the double, shift and long-immediate decoder
`timescale 1ns/10ps
module tb_dfl_decode;
  import dfl_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, cfg_long_mode = 1'b1, instr_valid = 1'b0;
  logic carry_flag = 1'b0, fpu_done = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [63:0] src_a_val = 64'h0, src_b_val = 64'h0, dest_val = 64'h0, fpu_result = 64'h0;
  logic busy, wb_valid, carry_wr, carry_val, illegal_instr, fpu_start;
  logic [4:0] wb_reg;
  logic [63:0] wb_data, fpu_lhs, fpu_rhs;
  dfl_fp_op_e fpu_op;
  int error_cnt = 0;
  int checked = 0;

  dfl_decode DUT
  (
    .clk, .sys_rst, .cfg_long_mode, .instr_valid, .instr, .src_a_val, .src_b_val,
    .dest_val, .carry_flag, .fpu_done, .fpu_result, .busy, .wb_valid, .wb_reg,
    .wb_data, .carry_wr, .carry_val, .illegal_instr, .fpu_start, .fpu_op,
    .fpu_lhs, .fpu_rhs
  );

  always #50 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One instruction for one cycle; returns just after the edge that answers it
  task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
                       input logic [63:0] d, input logic c);
    @(posedge clk);
    instr <= ins;
    src_a_val <= a;
    src_b_val <= b;
    dest_val <= d;
    carry_flag <= c;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic expect_wb(input logic [31:0] ins, input logic [63:0] data, input logic cw);
    chk(wb_valid, 1'b1);
    chk(wb_reg, ins[25:21]);
    chk(wb_data, data);
    chk(carry_wr, cw);
    chk(illegal_instr, 1'b0);
  endtask

  task automatic test_arith;
    logic [10:0] fn [5] = '{FN_DOUBLE_ADD, FN_DOUBLE_REVERSE_SUBTRACT, FN_DOUBLE_MULTIPLY, FN_DOUBLE_DIVIDE, FN_DSQRT};
    dfl_fp_op_e op [5] = '{DFL_FP_ADD, DFL_FP_RSUB, DFL_FP_MUL, DFL_FP_DIV, DFL_FP_SQRT};
    logic [31:0] ins;
    for (int i = 0; i < 5; i++)
    begin
      ins = {OPC_FLOAT, 5'h4, 5'h1, 5'h2, fn[i]};
      issue(ins, 64'h4000000000000000, 64'h3ff0000000000000, 64'h0, 1'b0);
      chk(fpu_start, 1'b1);
      chk(busy, 1'b1);
      chk(fpu_op, op[i]);
      chk(fpu_lhs, 64'h3ff0000000000000);
      chk(fpu_rhs, 64'h4000000000000000);
      // A shift offered while the unit works must be dropped, not queued
      @(posedge clk);
      instr <= {OPC_SHIFTI, 5'h7, 5'h1, 16'h0};
      instr_valid <= 1'b1;
      fpu_done <= 1'b1;
      fpu_result <= 64'h5a00 + 64'(i);
      @(posedge clk);
      fpu_done <= 1'b0;
      instr_valid <= 1'b0;
      #1;
      expect_wb(ins, 64'h5a00 + 64'(i), 1'b0);
      chk(busy, 1'b0);
      @(posedge clk);
      #1;
      chk(wb_valid, 1'b0);
    end
    $display("test_arith done");
  endtask

  task automatic test_compare;
    logic [10:0] fn [7] = '{FN_DUN, FN_DLT, FN_DEQ, FN_DLE, FN_DGT, FN_DNE, FN_DGE};
    logic [63:0] b [4] = '{64'h3ff0000000000000, 64'h4000000000000000, 64'h0,
                           64'h3ff0000000000000};
    logic [63:0] a [4] = '{64'h4000000000000000, 64'h3ff0000000000000,
                           64'h8000000000000000, 64'h7ff8000000000000};
    logic [6:0] e [4] = '{7'h2a, 7'h07, 7'h19, 7'h42};
    logic [31:0] ins;
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 7; j++)
      begin
        ins = {OPC_FLOAT, 5'h6, 5'h1, 5'h2, fn[j]};
        issue(ins, a[k], b[k], 64'h0, 1'b0);
        expect_wb(ins, {63'h0, e[k][6 - j]}, 1'b0);
      end
    $display("test_compare done");
  endtask

  task automatic test_convert;
    logic [10:0] fn [6] = '{FN_DFLT, FN_DFLT, FN_DOUBLE_TO_LONG, FN_DOUBLE_TO_LONG, FN_DOUBLE_TO_LONG, FN_DOUBLE_TO_LONG};
    logic [63:0] a [6] = '{64'h3, 64'hffffffffffffffff, 64'h4004000000000000,
                           64'hc004000000000000, 64'h7ff8000000000000, 64'h7fe0000000000000};
    logic [63:0] e [6] = '{64'h4008000000000000, 64'hbff0000000000000, 64'h2,
                           64'hfffffffffffffffe, LONG_MAX, LONG_MAX};
    logic [31:0] ins;
    for (int i = 0; i < 6; i++)
    begin
      ins = {OPC_FLOAT, 5'h8, 5'h1, 5'h0, fn[i]};
      issue(ins, a[i], 64'h0, 64'h0, 1'b0);
      expect_wb(ins, e[i], 1'b0);
    end
    $display("test_convert done");
  endtask

  // Back to back, so each answer is checked while the next one is taken
  task automatic test_shift;
    logic [15:0] lo [7] = '{{3'h0, PFX_SRL, 5'h4}, {3'h0, PFX_SRA, 5'h4},
                            {3'h0, PFX_SLL, 5'h1f}, {3'h0, PFX_SRL, 5'h0},
                            16'h409c, 16'h6100, 16'h4003};
    logic [63:0] e [7] = '{64'h08000001, 64'hf8000001, 64'h80000000, 64'h80000011,
                           64'h8, 64'h11, 64'h0};
    for (int i = 0; i <= 7; i++)
    begin
      @(posedge clk);
      src_a_val <= 64'hffffffff80000011;
      instr_valid <= (i < 7);
      if (i < 7)
        instr <= {OPC_SHIFTI, 5'h5, 5'h1, lo[i]};
      #1;
      if (i > 0)
        expect_wb({OPC_SHIFTI, 5'h5, 5'h1, lo[i - 1]}, e[i - 1], 1'b0);
    end
    $display("test_shift done");
  endtask

  task automatic test_long;
    logic [63:0] d [2] = '{64'hfffffffffffffff0, 64'h5};
    logic [15:0] imm [2] = '{16'h0010, 16'hfffe};
    logic [64:0] r;
    logic [31:0] ins;
    for (int k = 0; k < 4; k++)
      for (int s = 0; s < 8; s++)
      begin
        ins = {OPC_LONGIMM, 5'h9, 5'(s), imm[k % 2]};
        r = {1'b0, {48{imm[k % 2][15]}}, imm[k % 2]} + {1'b0, s[0] ? ~d[k % 2] : d[k % 2]}
            + 65'(s[1] ? k / 2 : s[0]);
        issue(ins, 64'h0, 64'h0, d[k % 2], 1'(k / 2));
        expect_wb(ins, r[63:0], !s[2]);
        if (!s[2])
          chk(carry_val, r[64]);
      end
    ins = {OPC_LONGIMM, 5'h9, SUB_OR, 16'h8001};
    issue(ins, 64'h0, 64'h0, 64'h123456789abcdef0, 1'b1);
    expect_wb(ins, 64'hffffffffffffdef1, 1'b0);
    ins = {OPC_LONGIMM, 5'h9, SUB_AND, 16'h00ff};
    issue(ins, 64'h0, 64'h0, 64'h123456789abcdef0, 1'b1);
    expect_wb(ins, 64'hf0, 1'b0);
    $display("test_long done");
  endtask

  // Mode off for the first three entries; the shift stays legal there
  task automatic test_illegal;
    logic [31:0] ins [7] = '{{OPC_FLOAT, 15'h0, FN_DOUBLE_ADD}, {OPC_LONGIMM, 26'h0},
                             {OPC_SHIFTI, 5'h2, 5'h1, 3'h0, PFX_SLL, 5'h1},
                             {OPC_FLOAT, 15'h0, 11'h7ff}, {6'h0, 26'h0},
                             {OPC_LONGIMM, 5'h0, 5'h12, 16'h0},
                             {OPC_SHIFTI, 5'h2, 5'h1, 3'h0, 8'h30, 5'h1}};
    logic [6:0] ill = 7'b1101011;
    logic [6:0] wb = 7'b0010000;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      cfg_long_mode <= (i > 2);
      issue(ins[i], 64'h3, 64'h0, 64'h0, 1'b0);
      chk(illegal_instr, ill[6 - i]);
      chk(wb_valid, wb[6 - i]);
      chk(fpu_start, 1'b0);
    end
    $display("test_illegal done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(wb_valid, 1'b0);
    chk(busy, 1'b0);
    chk(wb_data, DATA_RST);
    test_arith();
    test_compare();
    test_convert();
    test_shift();
    test_long();
    test_illegal();
    report_and_stop();
  end

  // About 90 instructions of a few cycles each; 20000 cycles is ample
  initial
  begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
endmodule

bind dfl_decode dfl_decode_checker u_chk
(
  .clk, .sys_rst, .cfg_long_mode, .instr_valid, .instr, .src_a_val, .src_b_val,
  .dest_val, .carry_flag, .fpu_done, .fpu_result, .busy, .wb_valid, .wb_reg,
  .wb_data, .carry_wr, .carry_val, .illegal_instr, .fpu_start, .fpu_op,
  .fpu_lhs, .fpu_rhs
);
